// file: rtl/pwm_submodule.v
`timescale 1ns/100ps
`include "pwm_edges_regs.vh"
module pwm_submodule
#(
   parameter NTRIP = 4
)
(
   input wire ref_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [NTRIP-1:0] protectionInput,
   output reg pwmOutA,
   output reg pwmOutB,
   output wire irq
);
   reg [15:0] filt_q;
   reg [1:0] ctrl_q;
   reg [15:0] start_q;
   reg [15:0] mod_q;
   reg [15:0] onA_q;
   reg [15:0] offA_q;
   reg [15:0] onB_q;
   reg [15:0] offB_q;
   reg [15:0] count_q;
   reg [NTRIP:0] stat_q;
   reg [NTRIP:0] mask_q;
   reg [NTRIP-1:0] sync1_q;
   reg [NTRIP-1:0] sync2_q;
   reg [NTRIP-1:0] filtPrev_q;
   wire [NTRIP-1:0] filtered;
   wire [NTRIP:0] events;
   wire wrEn;
   wire atMod;
   wire [15:0] countNext;
   reg hit;
   reg [31:0] rdata;

   assign pready = 1'b1;
   assign wrEn = psel & penable & pwrite;
   assign irq = |(stat_q & mask_q);
   assign atMod = (count_q == mod_q);
   // next timer value: held at start while stopped, reload at modulus
   assign countNext = !ctrl_q[`CTRL_RUN_BIT] ? start_q :
                      (atMod ? start_q : count_q + 16'h0001);

   // two-flop synchronisers on the trip pins
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync1_q <= {NTRIP{1'b0}};
         sync2_q <= {NTRIP{1'b0}};
      end
      else
      begin
         sync1_q <= protectionInput;
         sync2_q <= sync1_q;
      end
   end

   // one filter per trip input, simulated fault ORed in
   genvar g;
   generate
      for (g = 0; g < NTRIP; g = g + 1)
      begin : gFilt
         trip_filter uFilt
         (
            .ref_clk(ref_clk),
            .rst(rst),
            .rawIn(sync2_q[g] | ctrl_q[`CTRL_SIM_BIT]),
            .widenEn(filt_q[`FILT_WIDEN_BIT]),
            .agreeSampleCount(filt_q[`AGREE_SAMPLE_COUNT_HI:`AGREE_SAMPLE_COUNT_LO]),
            .sampleInterval(filt_q[`SAMPLE_INTERVAL_HI:`SAMPLE_INTERVAL_LO]),
            .filtered(filtered[g])
         );
      end
   endgenerate

   // rising filtered trip sets flag next clock; reload event in bit 0
   assign events = {filtered & ~filtPrev_q, ctrl_q[`CTRL_RUN_BIT] & atMod};

   // register writes, sticky status, set wins over clear
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         filt_q <= `FILT_RESET;
         ctrl_q <= 2'h0;
         start_q <= 16'h0000;
         mod_q <= 16'h0000;
         onA_q <= 16'h0000;
         offA_q <= 16'h0000;
         onB_q <= 16'h0000;
         offB_q <= 16'h0000;
         stat_q <= {(NTRIP+1){1'b0}};
         mask_q <= {(NTRIP+1){1'b0}};
         filtPrev_q <= {NTRIP{1'b0}};
      end
      else
      begin
         filtPrev_q <= filtered;
         if (wrEn && paddr == `ADDR_FILT)
            filt_q <= pwdata[15:0] & `FILT_WMASK;
         else if (wrEn && paddr == `ADDR_CTRL)
            ctrl_q <= pwdata[1:0];
         else if (wrEn && paddr == `ADDR_START)
            start_q <= pwdata[15:0];
         else if (wrEn && paddr == `ADDR_MOD)
            mod_q <= pwdata[15:0];
         else if (wrEn && paddr == `ADDR_ON0)
            onA_q <= pwdata[15:0];
         else if (wrEn && paddr == `ADDR_OFF0)
            offA_q <= pwdata[15:0];
         else if (wrEn && paddr == `ADDR_ON1)
            onB_q <= pwdata[15:0];
         else if (wrEn && paddr == `ADDR_OFF1)
            offB_q <= pwdata[15:0];
         else if (wrEn && paddr == `ADDR_MASK)
            mask_q <= pwdata[NTRIP:0];
         if (wrEn && paddr == `ADDR_STAT)
            stat_q <= (stat_q & ~pwdata[NTRIP:0]) | events;
         else
            stat_q <= stat_q | events;
      end
   end

   // up-only counter, reload at modulus; negative start with equality compare gives signed mode
   always @(posedge ref_clk)
   begin
      if (rst)
         count_q <= 16'h0000;
      else
         count_q <= countNext;
   end

   // two outputs, high while the count lies from turn-on to turn-off inclusive
   // set against the next count so output and count line up; odd centred width
   // alignment and phase follow only from edge values
   always @(posedge ref_clk)
   begin
      if (rst || !ctrl_q[`CTRL_RUN_BIT])
      begin
         pwmOutA <= 1'b0;
         pwmOutB <= 1'b0;
      end
      else
      begin
         if (countNext == onA_q)
            pwmOutA <= 1'b1;
         else if (count_q == offA_q)
            pwmOutA <= 1'b0;
         if (countNext == onB_q)
            pwmOutB <= 1'b1;
         else if (count_q == offB_q)
            pwmOutB <= 1'b0;
      end
   end

   // read mux
   always @*
   begin
      hit = 1'b1;
      rdata = 32'h00000000;
      if (paddr == `ADDR_FILT)
         rdata = {16'h0000, filt_q};
      else if (paddr == `ADDR_CTRL)
         rdata = {30'h00000000, ctrl_q};
      else if (paddr == `ADDR_START)
         rdata = {16'h0000, start_q};
      else if (paddr == `ADDR_MOD)
         rdata = {16'h0000, mod_q};
      else if (paddr == `ADDR_ON0)
         rdata = {16'h0000, onA_q};
      else if (paddr == `ADDR_OFF0)
         rdata = {16'h0000, offA_q};
      else if (paddr == `ADDR_ON1)
         rdata = {16'h0000, onB_q};
      else if (paddr == `ADDR_OFF1)
         rdata = {16'h0000, offB_q};
      else if (paddr == `ADDR_COUNT)
         rdata = {16'h0000, count_q};
      else if (paddr == `ADDR_STAT)
         rdata[NTRIP:0] = stat_q;
      else if (paddr == `ADDR_MASK)
         rdata[NTRIP:0] = mask_q;
      else if (paddr == `ADDR_FSTAT)
         rdata[NTRIP-1:0] = filtered;
      else
         hit = 1'b0;
   end

   assign pslverr = psel & penable & ~hit;

   // registered read data, loaded in setup phase
   always @(posedge ref_clk)
   begin
      if (rst)
         prdata <= 32'h00000000;
      else if (psel && !penable)
         prdata <= rdata;
   end
endmodule

// file: rtl/pwm_edges_regs.vh
// Overview of operation
// - glitch-widen bit set stretches narrow trip pulses to at least two clocks
// - filter register bits 14 to 11 read zero, writes ignored
// - transition accepted after agree_sample_count plus three agreeing samples
// - each trip input sampled every sample_interval clocks
// - sample_interval zero passes the widened trip level straight through, registered once
// - submodule has own timer driving two outputs with independent edges
// - timer counts up only, reloads start value at modulus
// - each output has turn-on and turn-off compare values
// - no alignment mode; alignment comes from edge values only
// - start value reloaded on every counter reset, any signed value
// - start equal to minus modulus gives signed counting
// - signed mode with opposite edges gives odd-width pulse centred on zero
// - turn-on equal to start value gives edge-aligned pulses
// - common offset on both edges shifts phase, keeps duty
// - latched trip flag set within two clocks of filtered fault, write one clears
// - trip simulate bit injects a fault into every filter
`ifndef PWM_EDGES_REGS_VH
`define PWM_EDGES_REGS_VH
`define ADDR_FILT 12'h0c8
`define ADDR_CTRL 12'h000
`define ADDR_START 12'h004
`define ADDR_MOD 12'h008
`define ADDR_ON0 12'h00c
`define ADDR_OFF0 12'h010
`define ADDR_ON1 12'h014
`define ADDR_OFF1 12'h018
`define ADDR_COUNT 12'h01c
`define ADDR_STAT 12'h020
`define ADDR_MASK 12'h024
`define ADDR_FSTAT 12'h028
`define FILT_WIDEN_BIT 15
`define AGREE_SAMPLE_COUNT_HI 10
`define AGREE_SAMPLE_COUNT_LO 8
`define SAMPLE_INTERVAL_HI 7
`define SAMPLE_INTERVAL_LO 0
`define FILT_WMASK 16'h87ff
`define FILT_RESET 16'h0000
`define CNT_BASE 4'h3
`define CTRL_RUN_BIT 0
`define CTRL_SIM_BIT 1
`define STAT_RELOAD_BIT 0
`define STAT_TRIP_LO 1
`endif

// file: rtl/trip_filter.v
`timescale 1ns/100ps
`include "pwm_edges_regs.vh"
module trip_filter
(
   input wire ref_clk,
   input wire rst,
   input wire rawIn,
   input wire widenEn,
   input wire [2:0] agreeSampleCount,
   input wire [7:0] sampleInterval,
   output reg filtered
);
   reg widen_q;
   reg [7:0] tick_q;
   reg [3:0] run_q;
   wire widenedIn;
   wire sampleNow;
   wire [3:0] need;

   // a pulse of one clock is held one extra clock when enabled
   assign widenedIn = rawIn | (widenEn & widen_q);
   assign sampleNow = (tick_q == sampleInterval);
   assign need = {1'b0, agreeSampleCount} + `CNT_BASE;

   // interval timer, run counter and filtered level
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         widen_q <= 1'b0;
         tick_q <= 8'h01;
         run_q <= 4'h0;
         filtered <= 1'b0;
      end
      else
      begin
         widen_q <= rawIn;
         if (sampleInterval == 8'h00)
         begin
            filtered <= widenedIn;
            tick_q <= 8'h01;
            run_q <= 4'h0;
         end
         else if (sampleNow)
         begin
            tick_q <= 8'h01;
            if (widenedIn == filtered)
               run_q <= 4'h0;
            else if (run_q + 4'h1 >= need)
            begin
               filtered <= widenedIn;
               run_q <= 4'h0;
            end
            else
               run_q <= run_q + 4'h1;
         end
         else
            tick_q <= tick_q + 8'h01;
      end
   end
endmodule

// file: bench/pwm_power_stage.sv
`timescale 1ns/100ps
module pwm_power_stage
(
   input wire ref_clk,
   output logic [3:0] protectionInput
);
   // sensors idle low, no fault
   initial protectionInput = 4'h0;
   // one sensor reports a fault for n clocks
   task automatic trip(input int ch, input int n);
      @(posedge ref_clk);
      protectionInput[ch] <= 1'b1;
      repeat (n) @(posedge ref_clk);
      protectionInput[ch] <= 1'b0;
   endtask
endmodule

// file: bench/pwm_submodule_properties.sv
`timescale 1ns/100ps
module pwm_submodule_properties
#(
   parameter NTRIP = 4
)
(
   input wire ref_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [NTRIP-1:0] protectionInput,
   input wire pwmOutA,
   input wire pwmOutB,
   input wire irq
);
   logic [15:0] filtQ;
   logic [NTRIP:0] maskQ;
   wire wr = psel && penable && pwrite;
   wire rdf = psel && !penable && !pwrite && paddr == 12'h0c8;
   wire pin = protectionInput[0];
   wire byp = filtQ[7:0] == 8'h00 && maskQ[1:0] == 2'h2 && !irq;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // shadow copies of filter and mask settings
   always @(posedge ref_clk)
      if (rst)
      begin
         filtQ <= 16'h0000;
         maskQ <= '0;
      end
      else if (wr && paddr == 12'h0c8)
         filtQ <= pwdata[15:0];
      else if (wr && paddr == 12'h024)
         maskQ <= pwdata[NTRIP:0];
   a_ready_always: assert property (pready) else $error("pready low");
   a_reserved_zero: assert property (rdf |=> prdata[14:11] == 4'h0)
      else $error("reserved bits set");
   a_unmapped_error: assert property (psel && penable && paddr == 12'h0fc |-> pslverr)
      else $error("no pslverr");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !pwmOutA && !pwmOutB
      && !irq && prdata == 32'h0) else $error("busy after reset");
   a_masked_quiet: assert property (maskQ == '0 |-> !irq) else $error("irq while masked");
   a_bypass_trip: assert property ((byp && !pin) [*4] ##1 pin |-> ##[1:6] irq)
      else $error("bypassed trip missed");
   a_widen_glitch: assert property ((byp && filtQ[15] && !pin) [*4] ##1 pin ##1 !pin
      |-> ##[1:5] irq) else $error("glitch missed");
   a_filter_latency: assert property ((filtQ[7:0] != 8'h00
      && maskQ[1:0] == 2'h2 && !irq && !pin) [*4] ##1 pin |-> !irq [*4])
      else $error("filter too fast");
   c_both_out: cover property (pwmOutA && pwmOutB);
   c_irq_rise: cover property ($rose(irq));
   c_slave_err: cover property (pslverr);
endmodule
bind pwm_submodule pwm_submodule_properties #(.NTRIP(NTRIP)) i_props (.ref_clk(ref_clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .protectionInput(protectionInput),
   .pwmOutA(pwmOutA), .pwmOutB(pwmOutB), .irq(irq));

// file: bench/pwm_submodule_tb.sv
`timescale 1ns/100ps
module pwm_submodule_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, pwmOutA, pwmOutB, irq;
   logic [3:0] protectionInput;
   int mismatches = 0;
   int checkCount = 0;
   int hi, per, w0;
   logic [15:0] fcfg[2] = '{16'h0002, 16'h0701};
   int fshort[2] = '{3, 8};
   int flong[2] = '{30, 14};
   always #20 ref_clk = ~ref_clk;
   pwm_submodule #(.NTRIP(4)) i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .protectionInput(protectionInput),
      .pwmOutA(pwmOutA), .pwmOutB(pwmOutB), .irq(irq));
   pwm_power_stage i_stage (.ref_clk(ref_clk), .protectionInput(protectionInput));
   // verdict and end of run
   task automatic finishTest();
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         mismatches++;
         finishTest();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // high time and period of one output
   task automatic measure(input logic b);
      logic [39:0] s;
      int r0;
      r0 = -1;
      hi = 0;
      per = 0;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge ref_clk);
         s[i] = b ? pwmOutB : pwmOutA;
      end
      for (int i = 1; i < 40; i++)
         if (s[i] === 1'b1 && s[i-1] === 1'b0)
            if (r0 < 0)
               r0 = i;
            else if (per == 0)
               per = i - r0;
      for (int i = r0; r0 >= 0 && i < r0 + per; i++)
         hi += s[i];
   endtask
   task automatic waitIrq();
      int n;
      for (n = 0; irq !== 1'b1 && n < 20; n++)
         @(posedge ref_clk);
      chk("irq", irq, 1);
   endtask
   // main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      apb(0, 12'h0c8, 0);
      chk("filter reset", rd, 32'h0);
      apb(1, 12'h0c8, 32'hffff_ffff);
      apb(0, 12'h0c8, 0);
      chk("filter bits", rd, 32'h87ff);
      apb(0, 12'h0fc, 0);
      chk("unmapped", rd, 32'h0);
      apb(1, 12'h004, 32'hfffc);
      apb(1, 12'h008, 32'h4);
      apb(1, 12'h00c, 32'hfffe);
      apb(1, 12'h010, 32'h2);
      apb(1, 12'h014, 32'hfffc);
      apb(1, 12'h018, 32'h0);
      apb(1, 12'h000, 32'h1);
      measure(0);
      chk("signed period", per, 9);
      chk("odd width", hi % 2, 1);
      w0 = hi;
      apb(1, 12'h00c, 32'hffff);
      apb(1, 12'h010, 32'h3);
      measure(0);
      chk("shifted width", hi, w0);
      measure(1);
      w0 = hi;
      apb(1, 12'h018, 32'h2);
      measure(1);
      chk("edge width", hi - w0, 2);
      apb(1, 12'h000, 32'h0);
      apb(1, 12'h020, 32'h1f);
      apb(1, 12'h024, 32'h2);
      apb(1, 12'h0c8, 32'h8000);
      i_stage.trip(0, 1);
      waitIrq();
      apb(0, 12'h020, 0);
      chk("glitch flag", rd, 32'h2);
      apb(1, 12'h020, 32'h2);
      apb(0, 12'h020, 0);
      chk("flag clear", rd, 32'h0);
      chk("irq clear", irq, 0);
      for (int i = 0; i < 2; i++)
      begin
         apb(1, 12'h0c8, {16'h0, fcfg[i]});
         i_stage.trip(0, fshort[i]);
         repeat (30) @(posedge ref_clk);
         apb(0, 12'h020, 0);
         chk("short trip", rd, 32'h0);
         i_stage.trip(0, flong[i]);
         waitIrq();
         apb(1, 12'h020, 32'h2);
         repeat (40) @(posedge ref_clk);
      end
      apb(1, 12'h0c8, 32'h0);
      apb(1, 12'h000, 32'h2);
      repeat (8) @(posedge ref_clk);
      apb(0, 12'h028, 0);
      chk("simulated levels", rd, 32'hf);
      apb(0, 12'h020, 0);
      chk("simulated flags", rd, 32'h1e);
      apb(1, 12'h000, 32'h0);
      apb(1, 12'h024, 32'h0);
      apb(0, 12'h028, 0);
      chk("sim removed", rd, 32'h0);
      chk("irq masked", irq, 0);
      finishTest();
   end
endmodule
